// ---- ptts_top.v ----
// Package thermal telemetry service logic
`include "ptts_defines.vh"
`timescale 1ns/1ps
module ptts_top #(
  parameter NCORE = 8,
  parameter TICK_CYC = `PTTS_TICK_CYC
) (
  input wire clk_sys, // System clock, 10 MHz
  input wire nrst, // Processor reset, active low
  input wire cmdValid, // Service request strobe
  input wire [3:0] cmdSvc, // Service select
  input wire [31:0] cmdParam, // Core select or clear mask
  input wire [31:0] cmdWdata, // Write data
  input wire cmdIsConfig, // Request is a config read/write command
  input wire pkgLowPower, // Package in C3 or deeper (pin)
  input wire cpuExecuting, // Processor executing (pin)
  input wire tccActive, // Thermal control activation (pin)
  input wire tccRamp, // Ramping back after activation (pin)
  input wire hotExternal, // Bidir hot signal driven externally (pin)
  input wire hotAsserted, // Bidir hot signal asserted (pin)
  input wire critTemp, // Critical temperature (pin)
  input wire [15:0] pkgTempIn, // Hottest die instantaneous temperature
  input wire [15:0] coreTempIn, // Selected core sensor temperature
  input wire [15:0] agentTempIn, // System agent temperature
  input wire [7:0] tjmaxIn, // Max junction temperature, deg C
  input wire [7:0] fanThreshIn, // Fan threshold, interface format
  input wire [12:0] ilimIn, // Current limit from supply logic
  output reg [3:0] coreSel_q, // Core select to sensor mux
  output reg rspValid_q, // Response strobe
  output reg [7:0] rspCode_q, // Completion code
  output reg [31:0] rspData_q, // Response data
  output reg popUpC2_q, // Request package pop-up to C2
  output reg [3:0] avgConst_q // Averaging constant to filter
);
  // ********************************
  // Reset and pin synchronisers
  // ********************************
  reg [1:0] rstSync_q;
  wire rstN;
  reg [6:0] pinA_q;
  reg [6:0] pinB_q;
  wire lowPwr, exec, thermal_control_activation, ramp, hotExt, hot, crit;

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rstSync_q <= 2'b00;
    end else begin
      rstSync_q <= {rstSync_q[0], 1'b1};
    end
  end
  assign rstN = rstSync_q[1];

  always @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      pinA_q <= 7'h00;
      pinB_q <= 7'h00;
    end else begin
      pinA_q <= {pkgLowPower, cpuExecuting, tccActive, tccRamp, hotExternal, hotAsserted,
                 critTemp};
      pinB_q <= pinA_q;
    end
  end
  assign {lowPwr, exec, thermal_control_activation, ramp, hotExt, hot, crit} = pinB_q;

  // ********************************
  // Millisecond tick and counters
  // ********************************
  wire msTick;
  reg [31:0] runTime_q;
  reg [31:0] thTime_q;
  reg [15:0] coreTemp_q;
  reg [15:0] agentTemp_q;

  ptts_ms_timer #(.TICK_CYC(TICK_CYC)) uTimer (
    .clk_sys(clk_sys),
    .rstN(rstN),
    .tick_q(msTick)
  );

  always @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      runTime_q <= 32'h00000000;
      thTime_q <= 32'h00000000;
      coreTemp_q <= 16'h0000;
      agentTemp_q <= 16'h0000;
    end else if (msTick) begin
      if (exec)
        runTime_q <= runTime_q + 32'h00000001;
      if ((thermal_control_activation || ramp) && !hotExt)
        thTime_q <= thTime_q + 32'h00000001;
      coreTemp_q <= coreTempIn;
      agentTemp_q <= agentTempIn;
    end
  end

  // ********************************
  // Thermal status logs
  // ********************************
  reg [2:0] stPrev_q;
  reg [2:0] log_q;
  wire [2:0] stNow;
  wire [2:0] rise;
  wire [2:0] keep;
  wire stRead;
  wire maskBad;

  assign stNow = {crit, hot, thermal_control_activation};
  assign rise = stNow & ~stPrev_q;
  assign stRead = cmdValid && (cmdSvc == `PTTS_SVC_THSTAT);
  assign maskBad = ((~cmdParam) & ~`PTTS_LOG_LEGAL) != 32'h00000000;
  assign keep = (stRead && !maskBad) ?
    {cmdParam[`PTTS_LOG_CRIT], cmdParam[`PTTS_LOG_HOT], cmdParam[`PTTS_LOG_TCC]} :
    3'b111;

  always @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      stPrev_q <= 3'b000;
      log_q <= 3'b000;
    end else begin
      stPrev_q <= stNow;
      log_q <= (log_q & keep) | rise;
    end
  end

  // ********************************
  // Service decode and response
  // ********************************
  reg wake_q;
  reg [12:0] ilim_q;
  reg [31:0] dataD;
  reg [7:0] codeD;
  wire [31:0] stWord;

  assign stWord = {26'h0000000, log_q[2], stNow[2], log_q[1], stNow[1], log_q[0], stNow[0]};

  always @* begin
    dataD = 32'h00000000;
    codeD = `PTTS_CC_OK;
    case (cmdSvc)
      `PTTS_SVC_WAKE_WR: dataD = 32'h00000000;
      `PTTS_SVC_WAKE_RD: dataD = {31'h00000000, wake_q};
      `PTTS_SVC_RUNTIME: dataD = runTime_q;
      `PTTS_SVC_PKGTEMP: dataD = {16'h0000, pkgTempIn};
      `PTTS_SVC_CORETEMP: begin
        if (cmdParam > NCORE)
          codeD = `PTTS_CC_BADPARAM;
        else if (cmdParam == NCORE)
          dataD = {16'h0000, agentTemp_q};
        else
          dataD = {16'h0000, coreTemp_q};
      end
      `PTTS_SVC_TARGET: dataD = {8'h00, tjmaxIn, fanThreshIn, 8'h00};
      `PTTS_SVC_THSTAT: begin
        if (maskBad)
          codeD = `PTTS_CC_FAIL;
        dataD = stWord;
      end
      `PTTS_SVC_AVG_WR: dataD = 32'h00000000;
      `PTTS_SVC_AVG_RD: dataD = {28'h0000000, avgConst_q};
      `PTTS_SVC_THTIME: dataD = thTime_q;
      `PTTS_SVC_ILIMIT: dataD = {19'h00000, ilim_q};
      default: codeD = `PTTS_CC_BADPARAM;
    endcase
    if (cmdIsConfig && lowPwr && !wake_q) begin
      codeD = `PTTS_CC_TIMEOUT;
      dataD = 32'h00000000;
    end
  end

  always @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      wake_q <= 1'b0;
      avgConst_q <= `PTTS_AVG_RESET;
      ilim_q <= `PTTS_ILIM_RESET;
      coreSel_q <= 4'h0;
      rspValid_q <= 1'b0;
      rspCode_q <= 8'h00;
      rspData_q <= 32'h00000000;
      popUpC2_q <= 1'b0;
    end else begin
      ilim_q <= ilimIn;
      rspValid_q <= cmdValid;
      popUpC2_q <= cmdValid && cmdIsConfig && lowPwr && wake_q;
      if (cmdValid) begin
        rspCode_q <= codeD;
        rspData_q <= dataD;
        if (cmdSvc == `PTTS_SVC_CORETEMP)
          coreSel_q <= cmdParam[3:0];
        if (cmdSvc == `PTTS_SVC_WAKE_WR)
          wake_q <= cmdWdata[0];
        if (cmdSvc == `PTTS_SVC_AVG_WR && cmdWdata[3:0] <= `PTTS_AVG_MAX)
          avgConst_q <= cmdWdata[3:0];
      end
    end
  end
endmodule // ptts_top

// ---- ptts_defines.vh ----
// Constants for the package thermal telemetry service block
`ifndef PTTS_DEFINES_VH
`define PTTS_DEFINES_VH

// Service select codes
`define PTTS_SVC_WAKE_WR 4'h0
`define PTTS_SVC_WAKE_RD 4'h1
`define PTTS_SVC_RUNTIME 4'h2
`define PTTS_SVC_PKGTEMP 4'h3
`define PTTS_SVC_CORETEMP 4'h4
`define PTTS_SVC_TARGET 4'h5
`define PTTS_SVC_THSTAT 4'h6
`define PTTS_SVC_AVG_WR 4'h7
`define PTTS_SVC_AVG_RD 4'h8
`define PTTS_SVC_THTIME 4'h9
`define PTTS_SVC_ILIMIT 4'ha

// Completion codes
`define PTTS_CC_OK 8'h40
`define PTTS_CC_TIMEOUT 8'h82
`define PTTS_CC_BADPARAM 8'h90
`define PTTS_CC_FAIL 8'h90

// Thermal status word field positions
`define PTTS_ST_TCC 0
`define PTTS_LOG_TCC 1
`define PTTS_ST_HOT 2
`define PTTS_LOG_HOT 3
`define PTTS_ST_CRIT 4
`define PTTS_LOG_CRIT 5
// Mask bits allowed to be zero (log bit positions)
`define PTTS_LOG_LEGAL 32'h0000002a

// Reset values and averaging constant maximum
`define PTTS_AVG_RESET 4'h4
`define PTTS_AVG_MAX 4'h8
`define PTTS_ILIM_RESET 13'h0438

// Timing
`define PTTS_TICK_NS 1000000
`define PTTS_CLK_NS 100
`define PTTS_TICK_CYC (`PTTS_TICK_NS / `PTTS_CLK_NS)

`endif

// ---- ptts_ms_timer.v ----
// Millisecond tick generator
`include "ptts_defines.vh"
`timescale 1ns/1ps
module ptts_ms_timer #(
  parameter TICK_CYC = `PTTS_TICK_CYC
) (
  input wire clk_sys, // System clock
  input wire rstN, // Synchronised reset, active low
  output reg tick_q // One-cycle pulse each period
);
  reg [23:0] cnt_q;

  always @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      cnt_q <= 24'h000000;
      tick_q <= 1'b0;
    end else if (cnt_q == TICK_CYC - 1) begin
      cnt_q <= 24'h000000;
      tick_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 24'h000001;
      tick_q <= 1'b0;
    end
  end
endmodule // ptts_ms_timer

// ---- ptts_properties.sv ----
// Port-level checker for the thermal telemetry service block
`timescale 1ns/1ps
module ptts_properties #(
  parameter NCORE = 8
) (
  input wire clk_sys, // Clock
  input wire nrst, // Reset
  input wire cmdValid, // Request
  input wire [3:0] cmdSvc, // Service
  input wire [31:0] cmdParam, // Select or mask
  input wire cmdIsConfig, // Config command
  input wire [15:0] pkgTempIn, // Die temp
  input wire rspValid_q, // Response
  input wire [7:0] rspCode_q, // Code
  input wire [31:0] rspData_q, // Data
  input wire popUpC2_q, // Pop-up
  input wire [3:0] avgConst_q // Averaging
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  chk_pkg_live: assert property (
    cmdValid && cmdSvc == 4'h3 && !cmdIsConfig |=> rspData_q == {16'h0, $past(pkgTempIn)})
    else $error("package temperature word wrong");
  chk_core_range: assert property (
    cmdValid && cmdSvc == 4'h4 && !cmdIsConfig && cmdParam > NCORE |=> rspCode_q == 8'h90)
    else $error("core select out of range not refused");
  chk_avg_max: assert property (avgConst_q <= 4'h8)
    else $error("averaging constant above maximum");
  chk_popup_cause: assert property (
    popUpC2_q |-> rspValid_q && $past(cmdValid && cmdIsConfig))
    else $error("pop-up without config command");
  chk_timeout_cause: assert property (
    rspValid_q && rspCode_q == 8'h82 |-> $past(cmdIsConfig) && rspData_q == 32'h0)
    else $error("timeout code on non-config request");
  chk_avg_hold: assert property (
    $changed(avgConst_q) |-> $past(cmdValid && cmdSvc == 4'h7))
    else $error("averaging constant changed without write");
  chk_mask_fail: assert property (
    cmdValid && cmdSvc == 4'h6 && !cmdIsConfig && (~cmdParam & ~32'h2a) != 32'h0
    |=> rspCode_q == 8'h90) else $error("illegal mask accepted");
  chk_mask_ok: assert property (
    cmdValid && cmdSvc == 4'h6 && !cmdIsConfig && (~cmdParam & ~32'h2a) == 32'h0
    |=> rspCode_q == 8'h40 && rspData_q[31:6] == 26'h0) else $error("status read wrong");
endmodule // ptts_properties

bind ptts_top ptts_properties #(.NCORE(NCORE)) chk_u (.clk_sys(clk_sys), .nrst(nrst),
  .cmdValid(cmdValid), .cmdSvc(cmdSvc), .cmdParam(cmdParam), .cmdIsConfig(cmdIsConfig),
  .pkgTempIn(pkgTempIn), .rspValid_q(rspValid_q), .rspCode_q(rspCode_q),
  .rspData_q(rspData_q), .popUpC2_q(popUpC2_q), .avgConst_q(avgConst_q));

// ---- ptts_host_model.sv ----
// Host-side request model for the service block
`timescale 1ns/1ps
module ptts_host_model (
  input wire clk_sys, // Clock
  output reg cmdValid, // Request strobe
  output reg [3:0] cmdSvc, // Service
  output reg [31:0] cmdParam, // Select or mask
  output reg [31:0] cmdWdata, // Write data
  output reg cmdIsConfig // Config command
);
  initial begin
    cmdValid = 1'b0;
    cmdSvc = 4'h0;
    cmdParam = 32'h0;
    cmdWdata = 32'h0;
    cmdIsConfig = 1'b0;
  end
  // Returns in the cycle where the response stands
  task req(input [3:0] s, input [31:0] p, input [31:0] w, input c);
    begin
      @(posedge clk_sys) #1;
      cmdValid = 1'b1;
      cmdSvc = s;
      cmdParam = p;
      cmdWdata = w;
      cmdIsConfig = c;
      @(posedge clk_sys) #1;
      cmdValid = 1'b0;
      cmdParam = ~p;
      cmdWdata = ~w;
    end
  endtask
endmodule // ptts_host_model

// ---- ptts_top_tb.sv ----
// Self-checking bench for the thermal telemetry service block
`timescale 1ns/1ps
module ptts_top_tb;
  reg clk_sys, nrst, lp, ex, ta, rp, he, ha, ct;
  reg [15:0] pt, at;
  reg [12:0] il;
  reg [31:0] t0;
  wire cmdValid, cmdIsConfig, rspValid_q, popUpC2_q;
  wire [3:0] cmdSvc, coreSel_q, avgConst_q;
  wire [31:0] cmdParam, cmdWdata, rspData_q;
  wire [7:0] rspCode_q;
  integer num_errors, cmp_count, cyc;
  ptts_host_model host_u (.clk_sys(clk_sys), .cmdValid(cmdValid), .cmdSvc(cmdSvc),
    .cmdParam(cmdParam), .cmdWdata(cmdWdata), .cmdIsConfig(cmdIsConfig));
  ptts_top #(.NCORE(8), .TICK_CYC(10)) dut_u (.clk_sys(clk_sys), .nrst(nrst),
    .cmdValid(cmdValid), .cmdSvc(cmdSvc), .cmdParam(cmdParam), .cmdWdata(cmdWdata),
    .cmdIsConfig(cmdIsConfig), .pkgLowPower(lp), .cpuExecuting(ex), .tccActive(ta),
    .tccRamp(rp), .hotExternal(he), .hotAsserted(ha), .critTemp(ct), .pkgTempIn(pt),
    .coreTempIn(16'h0c3d), .agentTempIn(at), .tjmaxIn(8'h5f), .fanThreshIn(8'hf6),
    .ilimIn(il), .coreSel_q(coreSel_q), .rspValid_q(rspValid_q),
    .rspCode_q(rspCode_q), .rspData_q(rspData_q), .popUpC2_q(popUpC2_q),
    .avgConst_q(avgConst_q));
  task chk(input [8*6:1] nm, input [31:0] e, input [31:0] g);
    begin
      cmp_count = cmp_count + 1;
      if (g !== e) begin
        num_errors = num_errors + 1;
        $display("BAD %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task rd(input [3:0] s, input [31:0] p, input [31:0] e, input [7:0] c);
    begin
      host_u.req(s, p, 32'h0, 1'b0);
      chk("code", {24'h0, c}, rspCode_q);
      chk("data", e, rspData_q);
    end
  endtask
  // Counter growth over exactly 100 cycles, i.e. ten ticks
  task dt(input [3:0] s, input [31:0] e);
    begin
      host_u.req(s, 32'h0, 32'h0, 1'b0);
      t0 = rspData_q;
      repeat (98) @(posedge clk_sys);
      host_u.req(s, 32'h0, 32'h0, 1'b0);
      chk("delta", e, rspData_q - t0);
    end
  endtask
  task settle;
    begin
      repeat (5) @(posedge clk_sys);
      #1;
    end
  endtask
  task final_report;
    begin
      $display("errors %0d compares %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      num_errors = num_errors + 1;
      final_report;
    end
  end
  initial begin
    num_errors = 0;
    cmp_count = 0;
    cyc = 0;
    nrst = 1'b0;
    lp = 1'b0;
    ex = 1'b1;
    ta = 1'b0;
    rp = 1'b0;
    he = 1'b0;
    ha = 1'b0;
    ct = 1'b0;
    pt = 16'h1a2b;
    at = 16'h0e4f;
    il = 13'h0438;
    repeat (20) @(posedge clk_sys);
    #1 nrst = 1'b1;
    settle;
    chk("avg", 32'h4, {28'h0, avgConst_q});
    rd(4'ha, 32'h0, 32'h438, 8'h40);
    il = 13'h1123;
    rd(4'ha, 32'h0, 32'h1123, 8'h40);
    rd(4'h5, 32'h0, 32'h005ff600, 8'h40);
    rd(4'h3, 32'h0, 32'h1a2b, 8'h40);
    pt = 16'h2c3d;
    rd(4'h3, 32'h0, 32'h2c3d, 8'h40);
    host_u.req(4'h7, 32'h0, 32'h8, 1'b0);
    host_u.req(4'h7, 32'h0, 32'h9, 1'b0);
    rd(4'h8, 32'h0, 32'h8, 8'h40);
    host_u.req(4'h7, 32'h0, 32'h0, 1'b0);
    chk("avg", 32'h0, {28'h0, avgConst_q});
    host_u.req(4'h4, 32'h9, 32'h0, 1'b0);
    chk("code", 32'h90, {24'h0, rspCode_q});
    rd(4'h4, 32'h3, 32'h0c3d, 8'h40);
    chk("sel", 32'h3, {28'h0, coreSel_q});
    at = 16'h0d5e;
    settle;
    repeat (10) @(posedge clk_sys);
    rd(4'h4, 32'h8, 32'h0d5e, 8'h40);
    lp = 1'b1;
    settle;
    host_u.req(4'h1, 32'h0, 32'h0, 1'b1);
    chk("code", 32'h82, {24'h0, rspCode_q});
    host_u.req(4'h0, 32'h0, 32'h1, 1'b0);
    host_u.req(4'h1, 32'h0, 32'h0, 1'b1);
    chk("pop", 32'h1, {31'h0, popUpC2_q});
    chk("wake", 32'h1, rspData_q);
    lp = 1'b0;
    dt(4'h2, 32'd10);
    ex = 1'b0;
    settle;
    dt(4'h2, 32'd0);
    ta = 1'b1;
    he = 1'b1;
    settle;
    dt(4'h9, 32'd0);
    he = 1'b0;
    settle;
    dt(4'h9, 32'd10);
    ta = 1'b0;
    rp = 1'b1;
    settle;
    dt(4'h9, 32'd10);
    ha = 1'b1;
    settle;
    rd(4'h6, 32'hffffffff, 32'he, 8'h40);
    rd(4'h6, 32'hfffffffd, 32'he, 8'h40);
    rd(4'h6, 32'hffffffff, 32'hc, 8'h40);
    host_u.req(4'h6, 32'hfffffffe, 32'h0, 1'b0);
    chk("code", 32'h90, {24'h0, rspCode_q});
    ct = 1'b1;
    settle;
    rd(4'h6, 32'hffffffd7, 32'h3c, 8'h40);
    rd(4'h6, 32'hffffffff, 32'h14, 8'h40);
    final_report;
  end
endmodule // ptts_top_tb
